// [hw/pot_pkg.sv]
// constants, opcodes and states shared by the dual pot serial front end
// assumes a 100 MHz system clock sampling all pins
package pot_pkg;

    // ----------------------------------------
    // structure
    // ----------------------------------------
    localparam int POTS = 2;
    localparam int WIPER_W = 8;
    localparam int TAPS = 256;
    localparam int SET_WORDS = 4;
    localparam int SEL_W = 2;
    localparam int STRAP_W = 4;

    // ----------------------------------------
    // byte layouts
    // ----------------------------------------
    localparam int ID_TYPE_LSB = 4;
    localparam int INS_OP_LSB = 4;
    localparam int INS_SEL_LSB = 2;
    localparam int INS_POT_BIT = 0;
    localparam logic [2:0] LAST_BIT = 3'h7;
    // device type code; value is arbitrary
    localparam logic [3:0] TYPE_CODE = 4'h6;

    // ----------------------------------------
    // opcodes
    // ----------------------------------------
    localparam logic [3:0] OP_RD_WIPER = 4'h9;
    localparam logic [3:0] OP_WR_WIPER = 4'ha;
    localparam logic [3:0] OP_RD_SET = 4'hb;
    localparam logic [3:0] OP_WR_SET = 4'hc;
    localparam logic [3:0] OP_SET_TO_WIPER = 4'hd;
    localparam logic [3:0] OP_WIPER_TO_SET = 4'he;
    localparam logic [3:0] OP_GLB_SET_TO_WIPER = 4'h1;
    localparam logic [3:0] OP_GLB_WIPER_TO_SET = 4'h8;
    localparam logic [3:0] OP_INCDEC = 4'h2;
    localparam logic [3:0] OP_RD_STATUS = 4'h5;

    // ----------------------------------------
    // values and timing
    // ----------------------------------------
    localparam logic [7:0] WIPER_MIN = 8'h00;
    localparam logic [7:0] WIPER_MAX = 8'hff;
    localparam logic [7:0] SET_INIT = 8'h80;
    localparam int CLK_PERIOD_NS = 10;
    localparam int NV_WRITE_NS = 10_000_000;
    localparam int NV_WRITE_CYCLES = NV_WRITE_NS / CLK_PERIOD_NS;

    // ----------------------------------------
    // pins: {sck, cs_n, hold_n, wp_n, si, strap[3:0]}
    // ----------------------------------------
    localparam int PIN_W = 9;
    localparam int PIN_SCK = 8;
    localparam int PIN_CS = 7;
    localparam int PIN_HOLD = 6;
    localparam int PIN_WP = 5;
    localparam int PIN_SI = 4;
    // select resets low so a select held low through reset never looks like a fall
    localparam logic [8:0] PIN_RST = 9'h060;

    typedef enum logic [2:0] {ST_ID, ST_INSTR, ST_DATA, ST_INCDEC, ST_IGNORE} link_state_t;

endpackage

// [hw/setting_store.sv]
// four-word nonvolatile setting store of one pot
// assumes a synchronous write port and a registered read
`timescale 1ns/1ps
module setting_store #(
    parameter int WIDTH = pot_pkg::WIPER_W,
    parameter int DEPTH = pot_pkg::SET_WORDS,
    parameter logic [7:0] INIT = pot_pkg::SET_INIT
) (
    input wire logic i_clock,
    input wire logic i_rst_n,
    input wire logic i_we,
    input wire logic [$clog2(DEPTH)-1:0] i_waddr,
    input wire logic [WIDTH-1:0] i_wdata,
    input wire logic [$clog2(DEPTH)-1:0] i_raddr,
    output logic [WIDTH-1:0] o_rdata
);

    logic [WIDTH-1:0] mem [DEPTH];

    if (WIDTH > 8 || DEPTH < 2) begin : g_bad
        $error("setting_store: unsupported size");
    end

    // reset stands in for the contents present at power-up
    always_ff @(posedge i_clock or negedge i_rst_n) begin
        if (!i_rst_n) begin
            for (int i = 0; i < DEPTH; i++) begin
                mem[i] <= INIT[WIDTH-1:0];
            end
        end else if (i_we) begin
            mem[i_waddr] <= i_wdata;
        end
    end

    always_ff @(posedge i_clock or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_rdata <= '0;
        end else begin
            o_rdata <= mem[i_raddr];
        end
    end

endmodule

// [hw/tap_decoder.sv]
// one-hot tap switch decode of one wiper position
// assumes the wiper value is on the same clock
`timescale 1ns/1ps
module tap_decoder #(
    parameter int TAPS = pot_pkg::TAPS
) (
    input wire logic i_clock,
    input wire logic i_rst_n,
    input wire logic [$clog2(TAPS)-1:0] i_wiper,
    output logic [TAPS-1:0] o_sel
);

    localparam int SEL_W = $clog2(TAPS);

    if (TAPS < 2) begin : g_bad
        $error("tap_decoder: too few taps");
    end

    // all switches open in reset, exactly one closed afterwards
    for (genvar t = 0; t < TAPS; t++) begin : g_tap
        always_ff @(posedge i_clock or negedge i_rst_n) begin
            if (!i_rst_n) begin
                o_sel[t] <= 1'b0;
            end else begin
                o_sel[t] <= (i_wiper == SEL_W'(t));
            end
        end
    end

    // ----------------------------------------
    // checks
    // ----------------------------------------
    one_switch_a: assert property (@(posedge i_clock) disable iff (!i_rst_n)
        $onehot0(o_sel) && ($past(i_rst_n) -> $onehot(o_sel)))
        else $error("more or less than one tap switch closed");

    low_end_a: assert property (@(posedge i_clock) disable iff (!i_rst_n)
        i_wiper == '0 |=> o_sel[0])
        else $error("zero wiper did not select low terminal");

    high_end_a: assert property (@(posedge i_clock) disable iff (!i_rst_n)
        i_wiper == '1 |=> o_sel[TAPS-1])
        else $error("full wiper did not select high terminal");

endmodule

// [hw/dual_pot_serial_wiper_ctrl.sv]
// serial slave front end and wiper logic of a dual digital potentiometer
// assumes asynchronous serial pins, sampled by the 100 MHz i_clock
`timescale 1ns/1ps
module dual_pot_serial_wiper_ctrl #(
    parameter int NV_WRITE_CYCLES = pot_pkg::NV_WRITE_CYCLES
) (
    input wire logic i_clock,
    input wire logic i_rstn,
    input wire logic i_sck,
    input wire logic i_cs_n,
    input wire logic i_hold_n,
    input wire logic i_wp_n,
    input wire logic i_si,
    input wire logic [pot_pkg::STRAP_W-1:0] i_addr_strap_pins,
    output logic o_so,
    output logic o_so_oe_n,
    output logic [pot_pkg::TAPS-1:0] o_tap_sel_0,
    output logic [pot_pkg::TAPS-1:0] o_tap_sel_1,
    output logic o_write_busy,
    output logic o_standby
);

    localparam int CNT_W = $clog2(NV_WRITE_CYCLES + 1);
    localparam int POTS = pot_pkg::POTS;

    // busy_follows_a needs at least three busy cycles
    if (NV_WRITE_CYCLES < 3 || POTS != 2) begin : g_bad
        $error("dual_pot_serial_wiper_ctrl: unsupported parameters");
    end

    // ----------------------------------------
    // reset release and pin synchronisers
    // ----------------------------------------
    logic rst_meta;
    logic rst_n;
    logic [pot_pkg::PIN_W-1:0] pin_meta;
    logic [pot_pkg::PIN_W-1:0] pin_sync;
    logic sck_q;
    logic cs_q;

    always_ff @(posedge i_clock or negedge i_rstn) begin
        if (!i_rstn) begin
            rst_meta <= 1'b0;
            rst_n <= 1'b0;
        end else begin
            rst_meta <= 1'b1;
            rst_n <= rst_meta;
        end
    end

    always_ff @(posedge i_clock or negedge rst_n) begin
        if (!rst_n) begin
            pin_meta <= pot_pkg::PIN_RST;
            pin_sync <= pot_pkg::PIN_RST;
            sck_q <= 1'b0;
            cs_q <= 1'b0; // same as the synchroniser's reset level: no false fall
        end else begin
            pin_meta <= {i_sck, i_cs_n, i_hold_n, i_wp_n, i_si, i_addr_strap_pins};
            pin_sync <= pin_meta;
            sck_q <= pin_sync[pot_pkg::PIN_SCK];
            cs_q <= pin_sync[pot_pkg::PIN_CS];
        end
    end

    logic sck_s;
    logic cs_n_s;
    logic hold_n_s;
    logic wp_n_s;
    logic si_s;
    logic [pot_pkg::STRAP_W-1:0] strap_s;
    assign sck_s = pin_sync[pot_pkg::PIN_SCK];
    assign cs_n_s = pin_sync[pot_pkg::PIN_CS];
    assign hold_n_s = pin_sync[pot_pkg::PIN_HOLD];
    assign wp_n_s = pin_sync[pot_pkg::PIN_WP];
    assign si_s = pin_sync[pot_pkg::PIN_SI];
    assign strap_s = pin_sync[pot_pkg::STRAP_W-1:0];

    // ----------------------------------------
    // select, arm and pause
    // ----------------------------------------
    logic armed;
    logic paused;
    logic cs_fall;
    logic rise;
    logic fall;
    logic go;

    assign cs_fall = cs_q & ~cs_n_s;
    assign rise = sck_s & ~sck_q;
    assign fall = ~sck_s & sck_q;
    assign go = rise & ~cs_n_s & armed & ~paused;

    always_ff @(posedge i_clock or negedge rst_n) begin
        if (!rst_n) begin
            armed <= 1'b0;
        end else if (cs_fall) begin
            armed <= 1'b1;
        end
    end

    // hold is only looked at while the serial clock is low
    always_ff @(posedge i_clock or negedge rst_n) begin
        if (!rst_n) begin
            paused <= 1'b0;
        end else if (cs_n_s) begin
            paused <= 1'b0;
        end else if (!sck_s) begin
            paused <= ~hold_n_s;
        end
    end

    // ----------------------------------------
    // byte engine
    // ----------------------------------------
    pot_pkg::link_state_t state;
    logic [2:0] bit_cnt;
    logic [7:0] sr;
    logic [7:0] instr;
    logic [7:0] next_sr;
    logic byte_done;
    logic id_ok;
    logic instr_done;
    logic data_done;
    logic [3:0] op;
    logic [3:0] new_op;
    logic ipot;
    logic new_pot;

    assign next_sr = {sr[6:0], si_s};
    assign byte_done = go && bit_cnt == pot_pkg::LAST_BIT;
    assign id_ok = next_sr[pot_pkg::ID_TYPE_LSB +: 4] == pot_pkg::TYPE_CODE
        && next_sr[pot_pkg::STRAP_W-1:0] == strap_s;
    assign instr_done = byte_done && state == pot_pkg::ST_INSTR;
    assign data_done = byte_done && state == pot_pkg::ST_DATA;
    assign op = instr[pot_pkg::INS_OP_LSB +: 4];
    assign new_op = next_sr[pot_pkg::INS_OP_LSB +: 4];
    assign ipot = instr[pot_pkg::INS_POT_BIT];
    assign new_pot = next_sr[pot_pkg::INS_POT_BIT];

    always_ff @(posedge i_clock or negedge rst_n) begin
        if (!rst_n) begin
            sr <= 8'h00;
        end else if (go) begin
            sr <= next_sr;
        end
    end

    always_ff @(posedge i_clock or negedge rst_n) begin
        if (!rst_n) begin
            instr <= 8'h00;
        end else if (instr_done) begin
            instr <= next_sr;
        end
    end

    always_ff @(posedge i_clock or negedge rst_n) begin
        if (!rst_n) begin
            bit_cnt <= 3'h0;
        end else if (cs_n_s) begin
            bit_cnt <= 3'h0;
        end else if (go) begin
            bit_cnt <= bit_cnt + 3'h1;
        end
    end

    always_ff @(posedge i_clock or negedge rst_n) begin
        if (!rst_n) begin
            state <= pot_pkg::ST_ID;
        end else if (cs_n_s) begin
            state <= pot_pkg::ST_ID;
        end else if (byte_done) begin
            unique case (state)
                pot_pkg::ST_ID: begin
                    state <= id_ok ? pot_pkg::ST_INSTR : pot_pkg::ST_IGNORE;
                end
                pot_pkg::ST_INSTR: begin
                    unique case (new_op)
                        pot_pkg::OP_RD_WIPER, pot_pkg::OP_WR_WIPER, pot_pkg::OP_RD_SET,
                        pot_pkg::OP_WR_SET, pot_pkg::OP_RD_STATUS: begin
                            state <= pot_pkg::ST_DATA;
                        end
                        pot_pkg::OP_INCDEC: begin
                            state <= pot_pkg::ST_INCDEC;
                        end
                        default: begin
                            state <= pot_pkg::ST_IGNORE;
                        end
                    endcase
                end
                pot_pkg::ST_DATA: begin
                    state <= pot_pkg::ST_IGNORE;
                end
                pot_pkg::ST_INCDEC, pot_pkg::ST_IGNORE: begin
                    state <= state;
                end
            endcase
        end
    end

    // ----------------------------------------
    // setting writes and busy timer
    // ----------------------------------------
    logic [POTS-1:0] nv_we;
    logic [pot_pkg::SEL_W-1:0] wsel;
    logic [pot_pkg::SEL_W-1:0] rd_sel;
    logic [CNT_W-1:0] busy_cnt;
    logic busy;

    assign wsel = data_done ? instr[pot_pkg::INS_SEL_LSB +: 2] : next_sr[pot_pkg::INS_SEL_LSB +: 2];

    always_ff @(posedge i_clock or negedge rst_n) begin
        if (!rst_n) begin
            busy_cnt <= '0;
            busy <= 1'b0;
        end else if (|nv_we) begin
            busy_cnt <= CNT_W'(NV_WRITE_CYCLES);
            busy <= 1'b1;
        end else if (busy_cnt != '0) begin
            busy_cnt <= busy_cnt - 1'b1;
            busy <= busy_cnt != CNT_W'(1);
        end
    end

    // reset reads word zero so both wipers take their power-on setting
    always_ff @(posedge i_clock or negedge rst_n) begin
        if (!rst_n) begin
            rd_sel <= '0;
        end else if (instr_done) begin
            rd_sel <= next_sr[pot_pkg::INS_SEL_LSB +: 2];
        end
    end

    // ----------------------------------------
    // wiper loads from the setting store
    // ----------------------------------------
    // two stages: store read address, then registered read data
    logic [1:0] load_pend;
    logic [POTS-1:0] load_mask;
    logic load_req;

    assign load_req = instr_done
        && (new_op == pot_pkg::OP_SET_TO_WIPER || new_op == pot_pkg::OP_GLB_SET_TO_WIPER);

    always_ff @(posedge i_clock or negedge rst_n) begin
        if (!rst_n) begin
            load_pend <= 2'b01;
            load_mask <= '1;
        end else begin
            load_pend <= {load_pend[0], load_req};
            if (load_req) begin
                load_mask[0] <= new_op == pot_pkg::OP_GLB_SET_TO_WIPER || !new_pot;
                load_mask[1] <= new_op == pot_pkg::OP_GLB_SET_TO_WIPER || new_pot;
            end
        end
    end

    // ----------------------------------------
    // per pot: store, wiper, tap decode
    // ----------------------------------------
    logic [7:0] wiper [POTS];
    logic [7:0] rdata [POTS];
    logic [pot_pkg::TAPS-1:0] tap_sel [POTS];

    for (genvar p = 0; p < POTS; p++) begin : g_pot
        logic own;
        assign own = ipot == 1'(p);

        assign nv_we[p] = wp_n_s && !busy && (
            (data_done && op == pot_pkg::OP_WR_SET && own)
            || (instr_done && new_op == pot_pkg::OP_WIPER_TO_SET && new_pot == 1'(p))
            || (instr_done && new_op == pot_pkg::OP_GLB_WIPER_TO_SET));

        setting_store u_store (
            .i_clock(i_clock),
            .i_rst_n(rst_n),
            .i_we(nv_we[p]),
            .i_waddr(wsel),
            .i_wdata(data_done ? next_sr : wiper[p]),
            .i_raddr(rd_sel),
            .o_rdata(rdata[p])
        );

        always_ff @(posedge i_clock or negedge rst_n) begin
            if (!rst_n) begin
                wiper[p] <= pot_pkg::WIPER_MIN;
            end else if (load_pend[1] && load_mask[p]) begin
                wiper[p] <= rdata[p];
            end else if (data_done && op == pot_pkg::OP_WR_WIPER && own) begin
                wiper[p] <= next_sr;
            end else if (go && state == pot_pkg::ST_INCDEC && own) begin
                // steps stop at the ends instead of wrapping round
                if (si_s && wiper[p] != pot_pkg::WIPER_MAX) begin
                    wiper[p] <= wiper[p] + 8'h01;
                end else if (!si_s && wiper[p] != pot_pkg::WIPER_MIN) begin
                    wiper[p] <= wiper[p] - 8'h01;
                end
            end
        end

        tap_decoder u_taps (
            .i_clock(i_clock),
            .i_rst_n(rst_n),
            .i_wiper(wiper[p]),
            .o_sel(tap_sel[p])
        );
    end

    assign o_tap_sel_0 = tap_sel[0];
    assign o_tap_sel_1 = tap_sel[1];
    assign o_write_busy = busy;

    // ----------------------------------------
    // serial output and standby
    // ----------------------------------------
    logic [7:0] read_word;
    logic reading;

    always_comb begin
        unique case (op)
            pot_pkg::OP_RD_WIPER: read_word = wiper[ipot];
            pot_pkg::OP_RD_SET: read_word = rdata[ipot];
            pot_pkg::OP_RD_STATUS: read_word = {7'h00, busy};
            default: read_word = 8'h00;
        endcase
    end

    assign reading = !cs_n_s && !paused && state == pot_pkg::ST_DATA
        && (op == pot_pkg::OP_RD_WIPER || op == pot_pkg::OP_RD_SET
        || op == pot_pkg::OP_RD_STATUS);
    assign o_so_oe_n = ~reading;

    always_ff @(posedge i_clock or negedge rst_n) begin
        if (!rst_n) begin
            o_so <= 1'b0;
        end else if (fall && reading) begin
            o_so <= read_word[pot_pkg::LAST_BIT - bit_cnt];
        end
    end

    always_ff @(posedge i_clock or negedge rst_n) begin
        if (!rst_n) begin
            o_standby <= 1'b0;
        end else begin
            o_standby <= cs_n_s && !busy;
        end
    end

    // ----------------------------------------
    // checks
    // ----------------------------------------
    default clocking cb @(posedge i_clock);
    endclocking
    default disable iff (!rst_n);

    sequence s_nv_start;
        |nv_we;
    endsequence

    sequence s_busy_run;
        busy [*3];
    endsequence

    busy_follows_a: assert property (s_nv_start |=> s_busy_run)
        else $error("busy flag not raised by a setting write");
    busy_bound_a: assert property (busy_cnt <= CNT_W'(NV_WRITE_CYCLES))
        else $error("write timer beyond its limit");
    deselect_float_a: assert property (cs_n_s |-> o_so_oe_n)
        else $error("serial out driven while deselected");
    pause_float_a: assert property (paused |-> o_so_oe_n)
        else $error("serial out driven during pause");
    pause_keep_a: assert property (paused && !cs_n_s |=> $stable(sr) && $stable(instr))
        else $error("shift state changed during pause");
    unarmed_idle_a: assert property (!armed |-> state == pot_pkg::ST_ID && !(|nv_we))
        else $error("activity before first select");
    protect_block_a: assert property (!wp_n_s |-> nv_we == '0)
        else $error("setting write while protected");
    addr_reject_a: assert property (byte_done && state == pot_pkg::ST_ID && !id_ok
        |=> state == pot_pkg::ST_IGNORE)
        else $error("mismatched address accepted");
    sample_rise_a: assert property (go |=> sr == $past(next_sr))
        else $error("serial input not shifted on rising edge");
    step_up_a: assert property (go && state == pot_pkg::ST_INCDEC && si_s
        && wiper[ipot] != pot_pkg::WIPER_MAX && !load_pend[1]
        |=> wiper[ipot] == $past(wiper[ipot]) + 8'h01)
        else $error("increment step missing");

endmodule

// [verif/spi_host_model.sv]
// host-side serial master framing bytes into the pot front end
// assumes a 100 MHz i_clock; every pin moves on its falling edge
`timescale 1ns/1ps
module spi_host_model (
    input wire logic i_clock,
    input wire logic i_so,
    input wire logic i_so_oe_n,
    output logic o_sck,
    output logic o_cs_n,
    output logic o_hold_n,
    output logic o_si
);
    // ----------------------------------------
    // state
    // ----------------------------------------
    logic [7:0] rx;
    logic paused_oe;
    initial begin
        o_sck = 1'b0;
        o_cs_n = 1'b1;
        o_hold_n = 1'b1;
        o_si = 1'b0;
        rx = 8'h00;
        paused_oe = 1'b0;
    end
    // ----------------------------------------
    // byte and frame tasks
    // ----------------------------------------
    task automatic tick(input int n);
        repeat (n) @(negedge i_clock);
    endtask
    // sck period 16 clocks; it stands low outside frames
    task automatic xfer(input logic [7:0] tx, input bit pause);
        for (int i = 7; i >= 0; i--) begin
            o_si = tx[i];
            tick(8);
            o_sck = 1'b1;
            // a released line shows the inverse of its last bit
            rx[i] = i_so_oe_n ? ~i_so : i_so;
            tick(8);
            o_sck = 1'b0;
            if (pause && i == 4) begin
                tick(6);
                o_hold_n = 1'b0;
                tick(8);
                // one stray clock pulse that a paused device must ignore
                o_sck = 1'b1;
                tick(8);
                o_sck = 1'b0;
                tick(8);
                paused_oe = i_so_oe_n;
                o_hold_n = 1'b1;
            end
        end
    endtask
    task automatic frame(input logic [7:0] b0, b1, b2, input int n, input bit pause,
                         output logic [7:0] got);
        o_cs_n = 1'b0;
        tick(6);
        xfer(b0, 1'b0);
        xfer(b1, 1'b0);
        if (n > 2) xfer(b2, pause);
        got = rx;
        tick(6);
        o_cs_n = 1'b1;
        // released line must not show a stale bit
        o_si = ~o_si;
        tick(6);
    endtask
endmodule

// [verif/dual_pot_serial_wiper_ctrl_tb.sv]
// self-checking bench for the dual pot serial front end
// assumes spi_host_model drives the serial pins
`timescale 1ns/1ps
`define CHK(n, e, s) begin \
    compares++; \
    if ((s) !== (e)) begin \
        fail_count++; \
        $display("Error %s expected %0h seen %0h", n, e, s); \
    end \
end
module dual_pot_serial_wiper_ctrl_tb;
    localparam int NV = 600;
    localparam logic [3:0] STRAP = 4'h3;
    localparam logic [7:0] ID = {pot_pkg::TYPE_CODE, STRAP};
    typedef struct {
        logic [7:0] b0, b1, b2;
        int n;
        bit pause;
        logic [7:0] w0, w1, rd;
        bit chk;
    } row_t;
    logic clock, rstn, wp_n, sck, cs_n, hold_n, si, so, so_oe_n, busy, standby;
    logic [255:0] tap0, tap1;
    logic [7:0] got;
    logic [3:0] strap;
    int fail_count, compares, cnt;
    row_t rows[15];
    spi_host_model host (.i_clock(clock), .i_so(so), .i_so_oe_n(so_oe_n), .o_sck(sck),
        .o_cs_n(cs_n), .o_hold_n(hold_n), .o_si(si));
    dual_pot_serial_wiper_ctrl #(.NV_WRITE_CYCLES(NV)) dut (.i_clock(clock), .i_rstn(rstn),
        .i_sck(sck), .i_cs_n(cs_n), .i_hold_n(hold_n), .i_wp_n(wp_n), .i_si(si),
        .i_addr_strap_pins(strap), .o_so(so), .o_so_oe_n(so_oe_n), .o_tap_sel_0(tap0),
        .o_tap_sel_1(tap1), .o_write_busy(busy), .o_standby(standby));
    // ----------------------------------------
    // clock, tasks, watchdog
    // ----------------------------------------
    initial begin
        clock = 1'b0;
        forever #5 clock = ~clock;
    end
    task automatic power_up(input bit cs_low);
        @(negedge clock);
        rstn = 1'b0;
        if (cs_low) host.o_cs_n = 1'b0;
        repeat (10) @(negedge clock);
        rstn = 1'b1;
        repeat (20) @(negedge clock);
        `CHK("tap0", 256'h1 << pot_pkg::SET_INIT, tap0)
    endtask
    task automatic wait_idle();
        cnt = 0;
        while (busy !== 1'b0 && cnt < 2000) begin
            @(negedge clock);
            cnt++;
        end
        `CHK("busy", 1'b0, busy)
    endtask
    task automatic wrap_up();
        $display("compares %0d mismatches %0d", compares, fail_count);
        if (fail_count == 0 && compares > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    initial begin
        repeat (40000) @(posedge clock);
        fail_count++;
        wrap_up();
    end
    // ----------------------------------------
    // main sequence
    // ----------------------------------------
    initial begin
        rstn = 1'b0;
        wp_n = 1'b1;
        strap = STRAP;
        fail_count = 0;
        compares = 0;
        rows = '{
            '{ID, 8'ha0, 8'ha5, 3, 1'b0, 8'ha5, 8'h80, 8'h00, 1'b0},
            '{ID, 8'h90, 8'h00, 3, 1'b1, 8'ha5, 8'h80, 8'ha5, 1'b1},
            '{ID, 8'ha1, 8'hff, 3, 1'b0, 8'ha5, 8'hff, 8'h00, 1'b0},
            '{ID, 8'ha0, 8'h00, 3, 1'b0, 8'h00, 8'hff, 8'h00, 1'b0},
            '{ID, 8'hc9, 8'h3c, 3, 1'b0, 8'h00, 8'hff, 8'h00, 1'b0},
            '{ID, 8'hb9, 8'h00, 3, 1'b1, 8'h00, 8'hff, 8'h3c, 1'b1},
            '{ID, 8'hd9, 8'h00, 2, 1'b0, 8'h00, 8'h3c, 8'h00, 1'b0},
            '{ID, 8'he5, 8'h00, 2, 1'b0, 8'h00, 8'h3c, 8'h00, 1'b0},
            '{ID, 8'hb5, 8'h00, 3, 1'b0, 8'h00, 8'h3c, 8'h3c, 1'b1},
            '{ID, 8'h21, 8'hff, 3, 1'b0, 8'h00, 8'h44, 8'h00, 1'b0},
            '{ID, 8'h20, 8'h00, 3, 1'b0, 8'h00, 8'h44, 8'h00, 1'b0},
            '{{pot_pkg::TYPE_CODE, 4'h2}, 8'ha0, 8'h77, 3, 1'b0, 8'h00, 8'h44, 8'h00, 1'b0},
            '{{~pot_pkg::TYPE_CODE, STRAP}, 8'ha0, 8'h77, 3, 1'b0, 8'h00, 8'h44, 8'h00, 1'b0},
            '{ID, 8'h18, 8'h00, 2, 1'b0, 8'h80, 8'h3c, 8'h00, 1'b0},
            '{ID, 8'h50, 8'h00, 3, 1'b0, 8'h80, 8'h3c, 8'h00, 1'b1}};
        power_up(1'b0);
        foreach (rows[k]) begin
            host.frame(rows[k].b0, rows[k].b1, rows[k].b2, rows[k].n, rows[k].pause, got);
            wait_idle();
            `CHK("tap0", 256'h1 << rows[k].w0, tap0)
            `CHK("tap1", 256'h1 << rows[k].w1, tap1)
            if (rows[k].chk) `CHK("read", rows[k].rd, got)
            if (rows[k].pause) `CHK("pause_oe_n", 1'b1, host.paused_oe)
            $display("row %0d done", k);
        end
        // blocked setting write leaves no busy period
        wp_n = 1'b0;
        host.frame(ID, 8'hcc, 8'h11, 3, 1'b0, got);
        `CHK("busy_wp", 1'b0, busy)
        wp_n = 1'b1;
        host.frame(ID, 8'hbc, 8'h00, 3, 1'b0, got);
        `CHK("set_wp", pot_pkg::SET_INIT, got)
        $display("protect test done");
        host.frame(ID, 8'hc8, 8'h5a, 3, 1'b0, got);
        `CHK("busy", 1'b1, busy)
        `CHK("standby", 1'b0, standby)
        `CHK("so_oe_n", 1'b1, so_oe_n)
        host.frame(ID, 8'h50, 8'h00, 3, 1'b0, got);
        `CHK("status", 8'h01, got)
        wait_idle();
        // standby is registered one edge behind the busy flag
        @(negedge clock);
        `CHK("standby", 1'b1, standby)
        host.frame(ID, 8'hb8, 8'h00, 3, 1'b0, got);
        `CHK("set_rd", 8'h5a, got)
        $display("busy test done");
        // straps moved: the new address must be accepted
        strap = 4'h2;
        host.frame({pot_pkg::TYPE_CODE, 4'h2}, 8'ha1, 8'h22, 3, 1'b0, got);
        `CHK("tap1_strap", 256'h1 << 8'h22, tap1)
        strap = STRAP;
        $display("strap test done");
        // select already low through reset: no falling edge seen yet
        power_up(1'b1);
        host.frame(ID, 8'ha0, 8'h11, 3, 1'b0, got);
        `CHK("tap0", 256'h1 << pot_pkg::SET_INIT, tap0)
        host.frame(ID, 8'ha0, 8'h11, 3, 1'b0, got);
        `CHK("tap0", 256'h1 << 8'h11, tap0)
        $display("power-up test done");
        wrap_up();
    end
endmodule
